/* ddio_field.sv */
module ddio_field (
	input  wire logic        clk,
	input  wire logic [26:0] level,
	output logic      [26:0] pins
);
	// Field levels change just after an edge, unrelated to the scan timing.
	always_ff @(posedge clk) begin
		pins <= level;
	end
endmodule

/* ddio_pkg.sv */
package ddio_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned FAST_PERIOD_NS = 2000;
	localparam int unsigned SCAN_PERIOD_US = 250;
	localparam int unsigned RELAY_SETTLE_MS = 10;
	localparam int unsigned FAST_CYCLES = FAST_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned SCAN_CYCLES = SCAN_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned RELAY_CYCLES = RELAY_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned N_FAST = 2;
	localparam int unsigned N_BASE_IN = 5;
	localparam int unsigned N_CARD_IN = 12;
	localparam int unsigned N_MC_IN = 6;
	localparam int unsigned N_ASSIGN_IN = N_BASE_IN + N_CARD_IN + N_MC_IN;
	localparam int unsigned N_BASE_OUT = 2;
	localparam int unsigned N_CARD_OUT = 10;
	localparam int unsigned N_MC_OUT = 2;
	localparam int unsigned N_OUT = N_BASE_OUT + N_CARD_OUT + N_MC_OUT;
	localparam int unsigned N_CARD_RELAY = 2;
	localparam logic [N_ASSIGN_IN-1:0] IN_FUNC_RESET = '0;
	typedef enum logic [0:0] {
		DDIO_RLY_NO_FAULT     = 1'b0,
		DDIO_RLY_NO_FAULT_ENA = 1'b1
	} ddio_relay_mode_t;
endpackage

/* ddio_top.sv */
// Summary of operation
// - Fast inputs one and two are sampled in hardware every 2 us.
// - Inputs three to seven are assignable, unassigned at reset, scanned every 250 us.
// - Input eight is the active-high hardware enable, wired straight into gating.
// - The output stage enables only while safe torque off input is asserted.
// - Software enable ANDs with hardware enable; an option forces it permanently on.
// - Hardware enable low keeps the output stage disabled.
// - Fault relay mode: closed on no fault, or on no fault and enabled.
// - Fault-only relay mode ignores enable, thermal current limit and regen threshold.
// - Any fault opens the relay and inhibits the stage; in fault-only mode the stage is off while the relay is open.
// - Relay status reports settled 10 ms after each command change.
// - Option card adds twelve assignable inputs scanned every 250 us.
// - Option card adds ten solid-state outputs refreshed every 250 us.
// - Option card adds relay outputs twenty-five and thirty, function driven.
// - Controller variant adds six assignable inputs, unassigned, scanned every 250 us.
// - Each assignable input is read active high or active low per its function.
module ddio_top (
	input  wire logic                               clk,
	input  wire logic                               sys_rst,
	input  wire logic [ddio_pkg::N_FAST-1:0]        fast_in,
	input  wire logic [ddio_pkg::N_ASSIGN_IN-1:0]   assign_in,
	input  wire logic                               hw_enable_in,
	input  wire logic                               safe_torque_off_input,
	input  wire logic [ddio_pkg::N_ASSIGN_IN-1:0]   in_assigned,
	input  wire logic [ddio_pkg::N_ASSIGN_IN-1:0]   in_active_low,
	input  wire logic                               card_fitted,
	input  wire logic                               mc_variant,
	input  wire logic                               sw_enable,
	input  wire logic                               sw_enable_force,
	input  wire logic                               relay_mode,
	input  wire logic                               fault,
	input  wire logic                               thermal_current_limit,
	input  wire logic                               regen_threshold,
	input  wire logic [ddio_pkg::N_OUT-1:0]         out_func,
	input  wire logic [ddio_pkg::N_CARD_RELAY-1:0]  card_relay_func,
	output logic      [ddio_pkg::N_FAST-1:0]        fast_sample,
	output logic                                    fast_strobe,
	output logic      [ddio_pkg::N_ASSIGN_IN-1:0]   in_state,
	output logic                                    scan_strobe,
	output logic      [ddio_pkg::N_OUT-1:0]         dig_out,
	output logic                                    stage_enable,
	output logic                                    fault_relay,
	output logic      [ddio_pkg::N_CARD_RELAY-1:0]  card_relay,
	output logic                                    relay_settled
);
	localparam int unsigned NA = ddio_pkg::N_ASSIGN_IN;
	localparam int unsigned NB = ddio_pkg::N_BASE_IN;
	localparam int unsigned NC = ddio_pkg::N_CARD_IN;
	localparam int unsigned NO = ddio_pkg::N_OUT;
	localparam int unsigned NBO = ddio_pkg::N_BASE_OUT;
	localparam int unsigned NCO = ddio_pkg::N_CARD_OUT;
	localparam int unsigned NR = ddio_pkg::N_CARD_RELAY;
	localparam int unsigned SYNC_W = ddio_pkg::N_FAST + NA + 2;

	// Two-stage synchronizer; stage one is read only by stage two.
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	always_ff @(posedge clk) begin
		sync_a <= {fast_in, assign_in, hw_enable_in, safe_torque_off_input};
		sync_b <= sync_a;
	end
	wire logic [ddio_pkg::N_FAST-1:0] fast_s = sync_b[SYNC_W-1 -: ddio_pkg::N_FAST];
	wire logic [NA-1:0]               asg_s  = sync_b[NA+1:2];
	wire logic                        hwen_s = sync_b[1];
	wire logic                        sto_s  = sync_b[0];

	logic [15:0] fast_cnt;
	logic [15:0] scan_cnt;
	logic [23:0] settle_cnt;
	wire logic fast_tick = (fast_cnt == 16'(ddio_pkg::FAST_CYCLES - 1));
	wire logic scan_tick = (scan_cnt == 16'(ddio_pkg::SCAN_CYCLES - 1));

	// Inputs present depend on fitted hardware and variant.
	wire logic [NA-1:0] present = {{ddio_pkg::N_MC_IN{mc_variant}}, {NC{card_fitted}}, {NB{1'b1}}};
	wire logic [NA-1:0] next_in_state = (asg_s ^ in_active_low) & in_assigned & present;
	wire logic [NO-1:0] out_present = {{ddio_pkg::N_MC_OUT{mc_variant}}, {NCO{card_fitted}}, {NBO{1'b1}}};

	wire logic sw_en_eff = sw_enable | sw_enable_force;
	wire logic next_stage_enable = hwen_s & sto_s & sw_en_eff & ~fault;
	wire logic relay_no_fault_ena = ~fault & stage_enable;
	wire logic next_fault_relay = (relay_mode == ddio_pkg::DDIO_RLY_NO_FAULT) ? ~fault : relay_no_fault_ena;
	wire logic [NR-1:0] next_card_relay = card_relay_func & {NR{card_fitted}};
	wire logic relay_change = (next_fault_relay != fault_relay) || (next_card_relay != card_relay);
	wire logic [NO-1:0] next_dig_out = out_func & out_present;
	wire logic [15:0] next_fast_cnt = fast_tick ? 16'h0000 : fast_cnt + 16'h0001;
	wire logic [15:0] next_scan_cnt = scan_tick ? 16'h0000 : scan_cnt + 16'h0001;
	wire logic settle_done = (settle_cnt == 24'(ddio_pkg::RELAY_CYCLES - 1));

	// Period counters start together, and the scan period is a whole multiple of the fast period.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fast_cnt <= '0;
			scan_cnt <= '0;
		end else begin
			fast_cnt <= next_fast_cnt;
			scan_cnt <= next_scan_cnt;
		end
	end

	// Fast inputs are latched once per fast period and flagged by a one-cycle strobe.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fast_sample <= '0;
			fast_strobe <= 1'b0;
		end else begin
			fast_strobe <= fast_tick;
			if (fast_tick) begin
				fast_sample <= fast_s;
			end
		end
	end

	// Scanned inputs and solid-state outputs share one refresh tick, so readers see a consistent set.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			in_state <= ddio_pkg::IN_FUNC_RESET;
			scan_strobe <= 1'b0;
			dig_out <= '0;
		end else begin
			scan_strobe <= scan_tick;
			if (scan_tick) begin
				in_state <= next_in_state;
				dig_out <= next_dig_out;
			end
		end
	end

	// Gating follows the synchronized inputs after one register; the fault relay in no-fault-and-enabled mode follows one register later.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage_enable <= 1'b0;
			fault_relay <= 1'b0;
			card_relay <= '0;
		end else begin
			stage_enable <= next_stage_enable;
			fault_relay <= next_fault_relay;
			card_relay <= next_card_relay;
		end
	end

	// The settle timer restarts on any relay command change.
	// The status is only a timing promise; nothing senses the contacts themselves.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			settle_cnt <= '0;
			relay_settled <= 1'b0;
		end else if (relay_change) begin
			settle_cnt <= '0;
			relay_settled <= 1'b0;
		end else if (!settle_done) begin
			settle_cnt <= settle_cnt + 24'h000001;
		end else begin
			relay_settled <= 1'b1;
		end
	end

	// All conditions that must hold together before the stage may switch on.
	sequence s_all_enables;
		hwen_s && sto_s && sw_en_eff && !fault;
	endsequence

	sequence s_relay_cmd_change;
		relay_change;
	endsequence

	sequence s_settle_low;
		!relay_settled;
	endsequence

	a_stage_needs_enables: assert property (@(posedge clk) disable iff (sys_rst)
		stage_enable |-> $past(hwen_s) && $past(sto_s) && $past(sw_en_eff))
		else $error("Stage enabled without all enables.");
	a_stage_on_enables: assert property (@(posedge clk) disable iff (sys_rst)
		s_all_enables |=> stage_enable)
		else $error("Stage stayed off with all enables present.");
	a_stage_off_sto: assert property (@(posedge clk) disable iff (sys_rst)
		!sto_s |=> !stage_enable)
		else $error("Stage on without safe torque off input.");
	a_stage_off_hw_low: assert property (@(posedge clk) disable iff (sys_rst)
		!hwen_s |=> !stage_enable)
		else $error("Stage on with hardware enable low.");
	a_fault_opens_relay: assert property (@(posedge clk) disable iff (sys_rst)
		fault |=> !fault_relay && !stage_enable)
		else $error("Fault did not open relay and stage.");
	a_open_inhibits: assert property (@(posedge clk) disable iff (sys_rst)
		!fault_relay && !$past(relay_mode) |-> !stage_enable)
		else $error("Stage on while fault relay open.");
	a_relay_mode_zero: assert property (@(posedge clk) disable iff (sys_rst)
		relay_mode == 1'b0 |=> fault_relay == !$past(fault))
		else $error("Fault-only relay mode wrong.");
	a_relay_mode_one: assert property (@(posedge clk) disable iff (sys_rst)
		relay_mode == 1'b1 && $past(relay_mode) |=> fault_relay == ($past(stage_enable) && !$past(fault)))
		else $error("Fault-and-enable relay mode wrong.");
	a_fast_period: assert property (@(posedge clk) disable iff (sys_rst)
		fast_strobe |=> !fast_strobe [*8])
		else $error("Fast sample strobe period wrong.");
	a_fast_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!fast_strobe |-> $stable(fast_sample))
		else $error("Fast sample changed between strobes.");
	a_scan_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		scan_strobe |-> scan_cnt == 16'h0000)
		else $error("Scan strobe out of step with its counter.");
	a_scan_updates: assert property (@(posedge clk) disable iff (sys_rst)
		!scan_strobe |-> $stable(in_state) && $stable(dig_out))
		else $error("Scanned state changed between scans.");
	a_out_refresh: assert property (@(posedge clk) disable iff (sys_rst)
		scan_tick |=> dig_out == $past(next_dig_out))
		else $error("Outputs not refreshed on scan.");
	a_card_out_absent: assert property (@(posedge clk) disable iff (sys_rst)
		scan_tick && !card_fitted |=> dig_out[NBO +: NCO] == '0)
		else $error("Card outputs driven without card.");
	a_card_in_absent: assert property (@(posedge clk) disable iff (sys_rst)
		scan_tick && !card_fitted |=> in_state[NB +: NC] == '0)
		else $error("Card inputs active without card.");
	a_mc_in_absent: assert property (@(posedge clk) disable iff (sys_rst)
		scan_tick && !mc_variant |=> in_state[NA-1 -: ddio_pkg::N_MC_IN] == '0)
		else $error("Controller inputs active on other variant.");
	a_card_relay_follow: assert property (@(posedge clk) disable iff (sys_rst)
		card_fitted |=> card_relay == $past(card_relay_func))
		else $error("Card relays do not follow their functions.");
	a_card_relay_absent: assert property (@(posedge clk) disable iff (sys_rst)
		!card_fitted |=> card_relay == '0)
		else $error("Card relays driven without card.");
	a_settle_clear: assert property (@(posedge clk) disable iff (sys_rst)
		s_relay_cmd_change |=> s_settle_low)
		else $error("Relay reported settled during change.");
	a_settle_rise: assert property (@(posedge clk) disable iff (sys_rst)
		relay_settled && !$past(relay_settled) |-> settle_done)
		else $error("Relay settled before the settle time.");
	a_unassigned_off: assert property (@(posedge clk) disable iff (sys_rst)
		scan_tick && !in_assigned[0] |=> !in_state[0])
		else $error("Unassigned input reads active.");
endmodule

/* ddio_top_bench.sv */
module ddio_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; $display("FAIL %s exp %h got %h", nm, ex, got); end end
	logic        clk, sys_rst, card_fitted, mc_variant, sw_enable, sw_enable_force, relay_mode, fault;
	logic        thermal_current_limit, regen_threshold, fast_strobe, scan_strobe, stage_enable, fault_relay, relay_settled;
	logic [26:0] level, pins;
	logic [22:0] in_assigned, in_active_low, in_state;
	logic [13:0] out_func, dig_out;
	logic [1:0]  card_relay_func, card_relay, fast_sample;
	logic [31:0] rnd;
	int          failures = 0, tests_run = 0, seed = 32'hbeee68ef;
	ddio_field u_ddio_field (.clk(clk), .level(level), .pins(pins));
	ddio_top u_ddio_top (.clk(clk), .sys_rst(sys_rst), .fast_in(pins[1:0]), .assign_in(pins[24:2]),
		.hw_enable_in(pins[25]), .safe_torque_off_input(pins[26]), .in_assigned(in_assigned),
		.in_active_low(in_active_low), .card_fitted(card_fitted), .mc_variant(mc_variant), .sw_enable(sw_enable),
		.sw_enable_force(sw_enable_force), .relay_mode(relay_mode), .fault(fault),
		.thermal_current_limit(thermal_current_limit), .regen_threshold(regen_threshold), .out_func(out_func),
		.card_relay_func(card_relay_func), .fast_sample(fast_sample), .fast_strobe(fast_strobe), .in_state(in_state),
		.scan_strobe(scan_strobe), .dig_out(dig_out), .stage_enable(stage_enable), .fault_relay(fault_relay),
		.card_relay(card_relay), .relay_settled(relay_settled));
	function automatic logic exp_stage();
		return level[25] & level[26] & (sw_enable | sw_enable_force) & ~fault;
	endfunction
	function automatic logic exp_relay();
		return ~fault & (relay_mode ? exp_stage() : 1'b1);
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_strobe(input bit scan);
		int k;
		k = 0;
		while ((scan ? scan_strobe : fast_strobe) !== 1'b1 && k < 30000) begin
			cyc(1);
			k++;
		end
		if (k == 30000) begin
			failures++;
			$display("FAIL strobe exp 1 got 0");
		end
	endtask
	task automatic finish_test();
		$display("tests_run %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#(95000 * 10);
		failures++;
		finish_test();
	end
	initial begin
		{sys_rst, card_fitted, mc_variant, sw_enable, sw_enable_force, relay_mode, fault} = 7'h40;
		{thermal_current_limit, regen_threshold, level, in_assigned, in_active_low} = '0;
		{out_func, card_relay_func} = '0;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 64; i++) begin
			@(posedge clk);
			level[26:25] <= 2'(i);
			{fault, relay_mode, sw_enable_force, sw_enable} <= 4'(i >> 2);
			{thermal_current_limit, regen_threshold} <= 2'(i + 1);
			cyc(5);
			`CHK("stage_enable", exp_stage(), stage_enable)
			`CHK("fault_relay", exp_relay(), fault_relay)
		end
		$display("test enable table done");
		@(posedge clk);
		{fault, relay_mode, sw_enable, level[26:25]} <= 5'h03 | 5'h04;
		cyc(5);
		@(posedge clk);
		fault <= 1'b1;
		cyc(1);
		`CHK("stage_enable", 1'b0, stage_enable)
		`CHK("fault_relay", 1'b0, fault_relay)
		`CHK("relay_settled", 1'b0, relay_settled)
		@(posedge clk);
		fault <= 1'b0;
		$display("test fault response done");
		for (int r = 0; r < 3; r++) begin
			@(posedge clk);
			rnd = $random(seed);
			{mc_variant, card_fitted, level} <= rnd[28:0];
			rnd = $random(seed);
			in_assigned <= rnd[22:0];
			rnd = $random(seed);
			{card_relay_func, in_active_low} <= rnd[24:0];
			rnd = $random(seed);
			out_func <= rnd[13:0];
			cyc(5);
			wait_strobe(1'b1);
			`CHK("in_state", (level[24:2] ^ in_active_low) & in_assigned & {{6{mc_variant}}, {12{card_fitted}}, 5'h1f}, in_state)
			`CHK("dig_out", out_func & {{2{mc_variant}}, {10{card_fitted}}, 2'h3}, dig_out)
			`CHK("card_relay", card_relay_func & {2{card_fitted}}, card_relay)
			wait_strobe(1'b0);
			`CHK("fast_sample", level[1:0], fast_sample)
			$display("test random scan %0d done", r);
		end
		@(posedge clk);
		sys_rst <= 1'b1;
		cyc(2);
		`CHK("stage_enable", 1'b0, stage_enable)
		`CHK("in_state", 23'h000000, in_state)
		`CHK("dig_out", 14'h0000, dig_out)
		@(posedge clk);
		sys_rst <= 1'b0;
		cyc(2);
		`CHK("fast_strobe", 1'b0, fast_strobe)
		$display("test mid reset done");
		finish_test();
	end
endmodule
